// ---- core/acs_defs.svh ----
// timing counts and field positions for the scan sequencer
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// conversion clock divider: system clocks per conversion clock
`define ACS_CLK_DIV 4
// conversion clocks per normal conversion and extra conversion clocks added for a stabilised restart
`define ACS_CONV_CYC 16
`define ACS_STAB_EXTRA 8
`define ACS_SCAN_LEN 4
// channel select register fields (scan group base)
`define ACS_SEL_W 3
// irq status bits
`define ACS_IRQ_END_BIT 0
`endif

// ---- core/acs_pkg.sv ----
// types shared by the scan sequencer files
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_STOP = 2'b00,
        ACS_STANDBY = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;
    typedef struct packed {
        logic [1:0] slot;
        logic [11:0] data;
    } acs_result_t;
endpackage : acs_pkg

// ---- core/acs_clkdiv.sv ----
// conversion clock enable divider
`timescale 1ns/1ps
`default_nettype none
module acs_clkdiv #(
    parameter int DIV = 4
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic align_i,
    output logic tick_o
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    logic [W-1:0] cnt_q;
    initial if (DIV < 2) $error("divider too small");
    // align restarts the phase so a restart begins on a fresh edge
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else if (align_i || cnt_q == W'(DIV - 1))
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end
    assign tick_o = (cnt_q == W'(DIV - 1)) && !align_i;
endmodule : acs_clkdiv
`default_nettype wire

// ---- core/acs_scan.sv ----
// hardware trigger no-wait scan one-shot sequencer
// What this block does
// - restart on next conversion clock edge
// - first restarted conversion includes stabilisation time
// - enable from stop enters standby
// - start bit alone never begins conversion
// - trigger converts four slots in order
// - each result stored in own register
// - one end interrupt after fourth channel
// - after scan start stays set, standby
// - trigger mid-conversion aborts, restarts slot zero
// - select write aborts, restarts new group
// - start rewrite aborts, restarts slot zero
// - start clear aborts into standby, enabled
// - enable clear in standby stops converter
// - start clear means triggers ignored
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module acs_scan #(
    parameter int DIV = `ACS_CLK_DIV,
    parameter int CONV_CYC = `ACS_CONV_CYC,
    parameter int STAB_EXTRA = `ACS_STAB_EXTRA
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic trigger_i,
    input wire logic [11:0] analog_data_i,
    output logic [`ACS_SEL_W-1:0] analog_chan_o,
    output acs_pkg::acs_state_t state_o,
    output logic irq_o
);
    import acs_pkg::*;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_SEL = 4'h1;
    localparam logic [3:0] A_STAT = 4'h2;
    localparam logic [3:0] A_MASK = 4'h3;
    localparam logic [3:0] A_RES0 = 4'h4;
    localparam int TOTAL = CONV_CYC + STAB_EXTRA;
    localparam int CW = $clog2(TOTAL + 1);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    initial if (CONV_CYC < 1 || STAB_EXTRA < 0) $error("bad conversion count");
    // slot counter and result array are sized for exactly four slots
    initial if (`ACS_SCAN_LEN != 4) $error("scan length must be four");
    initial if (DIV < 2) $error("divider too small");

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    logic trig_m_q, trig_s_q, trig_p_q;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trig_m_q <= 1'b0;
            trig_s_q <= 1'b0;
        end
        else
        begin
            trig_m_q <= trigger_i;
            trig_s_q <= trig_m_q;
        end
    end

    // previous settled level, for the rising edge only
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            trig_p_q <= 1'b0;
        else
            trig_p_q <= trig_s_q;
    end
    logic trig_ev;
    assign trig_ev = trig_s_q && !trig_p_q;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic enable_q, start_q;
    logic [`ACS_SEL_W-1:0] sel_q;
    logic mask_q, stat_q;
    logic wr_ctrl, wr_sel, wr_mask, rd_stat;
    logic en_val, start_val;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    assign wr_ctrl = wr_i && addr_i == A_CTRL;
    assign wr_sel = wr_i && addr_i == A_SEL;
    assign wr_mask = wr_i && addr_i == A_MASK;
    assign rd_stat = rd_i && addr_i == A_STAT;
    // start only sticks while enable is written with it
    assign en_val = wdata_i[0];
    assign start_val = wdata_i[1] && wdata_i[0];

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            enable_q <= 1'b0;
        else if (wr_ctrl)
            enable_q <= en_val;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            start_q <= 1'b0;
        else if (wr_ctrl)
            start_q <= start_val;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            sel_q <= '0;
        else if (wr_sel)
            sel_q <= wdata_i[`ACS_SEL_W-1:0];
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            mask_q <= 1'b0;
        else if (wr_mask)
            mask_q <= wdata_i[`ACS_IRQ_END_BIT];
    end

    // ----------------------------------------
    // sequencer events
    // ----------------------------------------
    acs_state_t state_q;
    logic [1:0] slot_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] limit;
    logic stab_q;
    logic pend_q;
    logic tick;
    logic done;
    logic end_ev;
    logic restart;
    logic go;
    logic abort;
    logic live;
    logic step;

    // a control write in the trigger cycle wins, so start alone never converts
    assign go = state_q == ACS_STANDBY && enable_q && start_q &&
        trig_ev && !wr_ctrl;

    // start or enable cleared drops the slot in flight
    assign abort = state_q == ACS_CONV && (!start_q || !enable_q);
    assign live = state_q == ACS_CONV && start_q && enable_q;

    // restart events during conversion
    assign restart = live &&
        (trig_ev || wr_sel || (wr_ctrl && start_val));

    // ----------------------------------------
    // conversion clock
    // ----------------------------------------
    acs_clkdiv #(.DIV(DIV)) u_div (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .align_i(restart),
        .tick_o(tick)
    );

    assign step = live && !restart && tick;

    // first slot after a restart carries the settling time
    assign limit = stab_q ? CW'(TOTAL - 1) : CW'(CONV_CYC - 1);
    assign done = step && !pend_q && cnt_q == limit;
    assign end_ev = done && slot_q == 2'(`ACS_SCAN_LEN - 1);

    // ----------------------------------------
    // state
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            state_q <= ACS_STOP;
        else
        begin
            case (state_q)
                ACS_STOP:
                begin
                    if (enable_q)
                        state_q <= ACS_STANDBY;
                end
                ACS_STANDBY:
                begin
                    if (!enable_q)
                        state_q <= ACS_STOP;
                    else if (go)
                        state_q <= ACS_CONV;
                end
                ACS_CONV:
                begin
                    if (abort)
                        state_q <= ACS_STANDBY;
                    else if (end_ev)
                        state_q <= ACS_STANDBY;
                end
                default:
                    state_q <= ACS_STOP;
            endcase
        end
    end

    // ----------------------------------------
    // slot and cycle counters
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            slot_q <= '0;
        else if (go || restart)
            slot_q <= '0;
        else if (done)
            slot_q <= slot_q + 2'd1;
    end

    // the aligning tick does not count toward the slot
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else if (go || restart || done)
            cnt_q <= '0;
        else if (step && !pend_q)
            cnt_q <= cnt_q + 1'b1;
    end

    // ----------------------------------------
    // settling and alignment flags
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            stab_q <= 1'b0;
        else if (restart)
            stab_q <= 1'b1;
        else if (go || done)
            stab_q <= 1'b0;
    end

    // the first tick only aligns, so a slot never starts mid conversion clock
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            pend_q <= 1'b0;
        else if (go || restart)
            pend_q <= 1'b1;
        else if (step)
            pend_q <= 1'b0;
    end

    // ----------------------------------------
    // results
    // ----------------------------------------
    acs_result_t cap;
    logic [11:0] res_q [`ACS_SCAN_LEN];
    assign cap = '{slot: slot_q, data: analog_data_i};

    // only a finished slot lands; an aborted one leaves the old value
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `ACS_SCAN_LEN; i++)
                res_q[i] <= '0;
        end
        else if (done)
            res_q[cap.slot] <= cap.data;
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            stat_q <= 1'b0;
        else if (end_ev)
            stat_q <= 1'b1; // set beats the read clear
        else if (rd_stat)
            stat_q <= 1'b0;
    end
    assign irq_o = stat_q && mask_q;

    // ----------------------------------------
    // read port
    // ----------------------------------------
    localparam logic [3:0] A_RES_END = A_RES0 + 4'h4;
    logic [15:0] rd_mux;
    logic [1:0] rd_slot;
    assign rd_slot = addr_i[1:0];

    always_comb
    begin
        rd_mux = 16'h0000;
        if (addr_i == A_CTRL)
            rd_mux = {12'h000, state_q, start_q, enable_q};
        else if (addr_i == A_SEL)
            rd_mux = {13'h0000, sel_q};
        else if (addr_i == A_STAT)
            rd_mux = {15'h0000, stat_q};
        else if (addr_i == A_MASK)
            rd_mux = {15'h0000, mask_q};
        else if (addr_i >= A_RES0 && addr_i < A_RES_END)
            rd_mux = {4'h0, res_q[rd_slot]};
    end

    // data stays put between reads
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= '0;
        else if (rd_i)
            rdata_o <= rd_mux;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // scan group base plus slot picks the analog input
    assign analog_chan_o = sel_q + `ACS_SEL_W'(slot_q);
    assign state_o = state_q;
endmodule : acs_scan
`default_nettype wire

// ---- sim/acs_scan_asserts.sv ----
// port checker for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_scan_asserts (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic trigger_i,
    input wire acs_pkg::acs_state_t state_o,
    input wire logic irq_o
);
    import acs_pkg::*;
    // cycles since trigger was last high, saturating
    logic [3:0] age_q;
    wire ctl_wr = wr_i && addr_i == 4'h0;
    wire conv = state_o == ACS_CONV;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            age_q <= 4'hF;
        else
            age_q <= trigger_i ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    end
    default clocking dcb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // a restart keeps converting and holds off the end irq for the next eight cycles
    property restart_p(cause);
        cause && conv |=> (conv && !$rose(irq_o)) [*8];
    endproperty
    a_enable_standby:
        assert property (ctl_wr && wdata_i[0] && state_o == ACS_STOP |-> ##2 state_o == ACS_STANDBY)
        else $error("enable missed standby");
    a_trigger_only:
        assert property ($rose(conv) |-> age_q < 4'h8) else $error("untriggered scan");
    a_irq_after_scan:
        assert property ($rose(irq_o) |-> $past(conv) || $past(conv, 2)) else $error("stray irq");
    a_start_clear:
        assert property (ctl_wr && wdata_i[1:0] == 2'b01 && conv |-> ##2 state_o == ACS_STANDBY)
        else $error("start clear missed standby");
    a_enable_clear:
        assert property (ctl_wr && !wdata_i[0] && state_o == ACS_STANDBY |-> ##2 state_o == ACS_STOP)
        else $error("enable clear missed stop");
    a_select_restart:
        assert property (restart_p(wr_i && addr_i == 4'h1)) else $error("no select restart");
    a_start_restart:
        assert property (restart_p(ctl_wr && wdata_i[1:0] == 2'b11)) else $error("no restart");
    a_end_standby:
        assert property ($fell(conv) |-> state_o == ACS_STANDBY) else $error("end not standby");
    c_scan_irq: cover property ($rose(irq_o));
    c_select_mid: cover property (wr_i && addr_i == 4'h1 && conv);
    c_stopped: cover property (ctl_wr && !wdata_i[0] && state_o == ACS_STANDBY);
endmodule : acs_scan_asserts
`default_nettype wire

// ---- sim/acs_scan_bench.sv ----
// random scan bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_scan_bench;
    import acs_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, trigger_i = 1'b0;
    logic irq_o, irq_p = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    logic [11:0] key = 12'h000, okey = 12'h000;
    logic [2:0] sel = 3'h0, analog_chan_o;
    acs_state_t state_o;
    int seed = 32'h80AF, err_count = 0, samples_checked = 0, rises = 0, cyc = 0;
    // each sample carries its channel, so a misplaced slot shows
    wire [11:0] analog_data_i = key ^ {9'h000, analog_chan_o};
    acs_scan #(.DIV(2), .CONV_CYC(2), .STAB_EXTRA(1)) dut (.clock_i, .rst_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .trigger_i, .analog_data_i, .analog_chan_o, .state_o, .irq_o);
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        irq_p <= irq_o;
        rises <= rises + int'(irq_o === 1'b1 && irq_p === 1'b0);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end
    function automatic logic [15:0] res_exp(input logic [11:0] k, input int s);
        return {4'h0, k ^ {9'h000, sel + 3'(s)}};
    endfunction : res_exp
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            err_count++;
            $display("mismatch at %0t: %h not %h", $time, seen, want);
        end
    endtask : check
    // reads pass a mask in v; gap cycle keeps strobes single
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] v,
        input logic [15:0] e = 16'h0000);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clock_i);
        if (!w)
            check(rdata_o & v, e);
    endtask : bus
    task automatic pulse();
        trigger_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        trigger_i <= 1'b0;
        @(posedge clock_i);
    endtask : pulse
    task automatic until_st(input acs_state_t s);
        int n;
        n = 0;
        while (state_o !== s && n < 300)
        begin
            @(posedge clock_i);
            n++;
        end
        check(16'(state_o), 16'(s));
    endtask : until_st
    // kind 0 plain, 1 retrigger, 2 new group, 3 start rewrite, 4 start cleared
    task automatic scan(input int kind, input logic m);
        int r0;
        r0 = rises;
        okey = key;
        key <= 12'($random(seed));
        pulse();
        until_st(ACS_CONV);
        key <= 12'($random(seed));
        if (kind == 2)
            sel = 3'($random(seed));
        case (kind)
            0: ;
            1: pulse();
            2: bus(1'b1, 4'h1, {13'h0000, sel});
            3: bus(1'b1, 4'h0, 16'h0003);
            default: bus(1'b1, 4'h0, 16'h0001);
        endcase
        if (kind == 4)
            repeat (40) @(posedge clock_i);
        until_st(ACS_STANDBY);
        check({15'h0000, irq_o}, {15'h0000, m && kind != 4});
        for (int s = int'(kind == 4); s < 4; s++)
            bus(1'b0, 4'(4 + s), 16'h0FFF, res_exp(kind == 4 ? okey : key, s));
        bus(1'b0, 4'h0, 16'h0003, kind == 4 ? 16'h0001 : 16'h0003);
        check(16'(rises - r0), 16'(m && kind != 4));
        bus(1'b0, 4'h2, 16'h0001, {15'h0000, kind != 4});
        bus(1'b0, 4'h2, 16'h0001, 16'h0000);
        $display("scan %0d done", kind);
    endtask : scan
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        bus(1'b0, 4'hF, 16'hFFFF, 16'h0000);
        bus(1'b1, 4'h0, 16'h0001);
        until_st(ACS_STANDBY);
        // software settling wait, generous on purpose
        repeat (60) @(posedge clock_i);
        sel = 3'($random(seed));
        bus(1'b1, 4'h1, {13'h0000, sel});
        bus(1'b1, 4'h0, 16'h0003);
        repeat (20) @(posedge clock_i);
        check(16'(state_o), 16'(ACS_STANDBY));
        scan(0, 1'b0);
        bus(1'b1, 4'h3, 16'h0001);
        for (int i = 0; i < 8; i++)
            scan(i % 4, 1'b1);
        scan(4, 1'b1);
        pulse();
        repeat (30) @(posedge clock_i);
        check(16'(state_o), 16'(ACS_STANDBY));
        bus(1'b1, 4'h0, 16'h0000);
        until_st(ACS_STOP);
        summarize();
    end
endmodule : acs_scan_bench
bind acs_scan acs_scan_asserts u_chk (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .trigger_i,
    .state_o, .irq_o);
`default_nettype wire
